/* File: tawad_top.sv */
`timescale 1ns/1ps
module tawad_top import tawad_pkg::*; #(
  parameter int W = 16
) (
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic reset_n, // sync reset, low active
  input wire logic clk_en, // freezes all state when low
  input wire logic sample_stb, // one-cycle accel sample strobe
  input wire logic signed [W-1:0] acc_x, // accel x sample
  input wire logic signed [W-1:0] acc_y, // accel y sample
  input wire logic signed [W-1:0] acc_z, // accel z sample
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, one cycle after strobe
  output logic second_irq_pin // second programmable interrupt
);
  // ==========================================================
  // configuration registers
  logic [7:0] pulse_and_route_config_q, pulse_and_route_config_d;
  logic [7:0] embedded_function_control_q, embedded_function_control_d;
  logic [7:0] angle_thr_q, angle_thr_d;
  logic [7:0] angle_lat_q, angle_lat_d;
  logic [7:0] axis_mask_q, axis_mask_d;
  logic [7:0] tilt_win_q, tilt_win_d;
  logic [7:0] tilt_thr_q, tilt_thr_d;

  // write decode; unmapped writes are dropped
  always_comb begin
    pulse_and_route_config_d = pulse_and_route_config_q;
    embedded_function_control_d = embedded_function_control_q;
    angle_thr_d = angle_thr_q;
    angle_lat_d = angle_lat_q;
    axis_mask_d = axis_mask_q;
    tilt_win_d = tilt_win_q;
    tilt_thr_d = tilt_thr_q;
    if (reg_wr) begin
      unique case (reg_addr)
        TAWAD_ADDR_PULSE_CFG: pulse_and_route_config_d = reg_wdata;
        TAWAD_ADDR_FUNC_CTRL: embedded_function_control_d = reg_wdata;
        TAWAD_ADDR_ANGLE_THR: angle_thr_d = reg_wdata;
        TAWAD_ADDR_ANGLE_LAT: angle_lat_d = reg_wdata;
        TAWAD_ADDR_AXIS_MASK: axis_mask_d = reg_wdata;
        TAWAD_ADDR_TILT_WIN: tilt_win_d = reg_wdata;
        TAWAD_ADDR_TILT_THR: tilt_thr_d = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pulse_and_route_config_q <= TAWAD_RST_PULSE_CFG;
      embedded_function_control_q <= TAWAD_RST_FUNC_CTRL;
      angle_thr_q <= TAWAD_RST_ANGLE_THR;
      angle_lat_q <= TAWAD_RST_ANGLE_LAT;
      axis_mask_q <= TAWAD_RST_AXIS_MASK;
      tilt_win_q <= TAWAD_RST_TILT_WIN;
      tilt_thr_q <= TAWAD_RST_TILT_THR;
    end else if (clk_en) begin
      pulse_and_route_config_q <= pulse_and_route_config_d;
      embedded_function_control_q <= embedded_function_control_d;
      angle_thr_q <= angle_thr_d;
      angle_lat_q <= angle_lat_d;
      axis_mask_q <= axis_mask_d;
      tilt_win_q <= tilt_win_d;
      tilt_thr_q <= tilt_thr_d;
    end
  end

  logic embedded_function_enable, angle_en, tilt_en, route_angle, route_tilt, latched;
  assign embedded_function_enable = embedded_function_control_q[TAWAD_FUNCTION_ENABLE_BIT];
  assign angle_en = embedded_function_enable
    && embedded_function_control_q[TAWAD_ANGLE_EN_BIT];
  assign tilt_en = embedded_function_enable
    && embedded_function_control_q[TAWAD_TILT_EN_BIT];
  assign route_angle = pulse_and_route_config_q[TAWAD_ROUTE_ANGLE_BIT];
  assign route_tilt = pulse_and_route_config_q[TAWAD_ROUTE_TILT_BIT];
  assign latched = pulse_and_route_config_q[TAWAD_LATCH_BIT];

  // ==========================================================
  // angle detector, one instance per semi-axis
  // limit assumes 1 g near full scale of a W-bit sample; a steep
  // threshold on a low full scale may never be reached
  logic signed [W:0] semi_val [TAWAD_SEMI_AXES];
  logic signed [W:0] angle_limit;
  logic [TAWAD_SEMI_AXES-1:0] semi_fire;
  assign angle_limit = $signed((W+1)'(angle_thr_q) << TAWAD_THR_SHIFT);
  assign semi_val[0] = {acc_x[W-1], acc_x};
  assign semi_val[1] = -{acc_x[W-1], acc_x};
  assign semi_val[2] = {acc_y[W-1], acc_y};
  assign semi_val[3] = -{acc_y[W-1], acc_y};
  assign semi_val[4] = {acc_z[W-1], acc_z};
  assign semi_val[5] = -{acc_z[W-1], acc_z};

  for (genvar i = 0; i < TAWAD_SEMI_AXES; i++) begin : g_semi
    tawad_semi_axis #(.W(W)) u_semi (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .sample_stb(sample_stb),
      .active(angle_en && axis_mask_q[7-i]),
      .value(semi_val[i]),
      .limit(angle_limit),
      .latency(angle_lat_q),
      .fire_q(semi_fire[i])
    );
  end

  logic angle_evt;
  assign angle_evt = |semi_fire;

  // ==========================================================
  // tilt detector: windowed average against last reference
  localparam int SW = W + 8;
  tawad_tilt_state_t tilt_state_q, tilt_state_d;
  logic signed [SW-1:0] sum_q [3];
  logic signed [SW-1:0] sum_d [3];
  logic signed [W:0] ref_q [3];
  logic signed [W:0] ref_d [3];
  logic ref_ok_q, ref_ok_d;
  logic [7:0] win_cnt_q, win_cnt_d;
  logic tilt_evt_q, tilt_evt_d;
  logic signed [W-1:0] acc_in [3];
  logic [7:0] win_len;
  assign acc_in[0] = acc_x;
  assign acc_in[1] = acc_y;
  assign acc_in[2] = acc_z;
  assign win_len = 8'h01 << tilt_win_q[2:0];

  always_comb begin
    logic signed [SW-1:0] avg;
    logic signed [W+1:0] diff;
    logic [W+1:0] tlim;
    logic moved;
    avg = '0;
    diff = '0;
    moved = 1'b0;
    tlim = (W+2)'(tilt_thr_q) << TAWAD_THR_SHIFT;
    tilt_state_d = tilt_state_q;
    sum_d = sum_q;
    ref_d = ref_q;
    ref_ok_d = ref_ok_q;
    win_cnt_d = win_cnt_q;
    tilt_evt_d = 1'b0;
    unique case (tilt_state_q)
      TAWAD_T_IDLE: begin
        ref_ok_d = 1'b0;
        win_cnt_d = 8'h00;
        for (int a = 0; a < 3; a++) sum_d[a] = '0;
        if (tilt_en) tilt_state_d = TAWAD_T_ACC;
      end
      TAWAD_T_ACC: begin
        if (!tilt_en) begin
          tilt_state_d = TAWAD_T_IDLE;
        end else if (sample_stb) begin
          for (int a = 0; a < 3; a++) sum_d[a] = sum_q[a] + SW'(acc_in[a]);
          win_cnt_d = win_cnt_q + 8'h01;
          if (win_cnt_d == win_len) tilt_state_d = TAWAD_T_CMP;
        end
      end
      TAWAD_T_CMP: begin
        for (int a = 0; a < 3; a++) begin
          avg = sum_q[a] >>> tilt_win_q[2:0];
          diff = {avg[W], avg[W:0]} - {ref_q[a][W], ref_q[a]};
          if (diff[W+1]) diff = -diff;
          if ($unsigned(diff) > tlim) moved = 1'b1;
          ref_d[a] = avg[W:0];
          sum_d[a] = '0;
        end
        tilt_evt_d = ref_ok_q && moved && tilt_en;
        if (moved || !ref_ok_q) ref_ok_d = 1'b1;
        else ref_d = ref_q; // small drifts do not creep the reference
        win_cnt_d = 8'h00;
        tilt_state_d = tilt_en ? TAWAD_T_ACC : TAWAD_T_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tilt_state_q <= TAWAD_T_IDLE;
      for (int a = 0; a < 3; a++) begin
        sum_q[a] <= '0;
        ref_q[a] <= '0;
      end
      ref_ok_q <= 1'b0;
      win_cnt_q <= 8'h00;
      tilt_evt_q <= 1'b0;
    end else if (clk_en) begin
      tilt_state_q <= tilt_state_d;
      sum_q <= sum_d;
      ref_q <= ref_d;
      ref_ok_q <= ref_ok_d;
      win_cnt_q <= win_cnt_d;
      tilt_evt_q <= tilt_evt_d;
    end
  end

  // ==========================================================
  // status flags, axis source, interrupt pin and read port
  logic angle_flag_q, angle_flag_d, tilt_flag_q, tilt_flag_d;
  logic [7:0] axis_src_q, axis_src_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic rd_src2;
  assign rd_src2 = reg_rd && (reg_addr == TAWAD_ADDR_FUNC_STATUS);

  // a new event in the read cycle wins over the read clear
  always_comb begin
    angle_flag_d = angle_evt || (angle_flag_q && !rd_src2);
    tilt_flag_d = tilt_evt_q || (tilt_flag_q && !rd_src2);
    axis_src_d = axis_src_q;
    for (int i = 0; i < TAWAD_SEMI_AXES; i++) begin
      if (angle_evt) axis_src_d[7-i] = semi_fire[i];
    end
    irq_d = (route_angle && (latched ? angle_flag_d : angle_evt))
      || (route_tilt && (latched ? tilt_flag_d : tilt_evt_q));
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        TAWAD_ADDR_PULSE_CFG: rdata_d = pulse_and_route_config_q;
        TAWAD_ADDR_FUNC_CTRL: rdata_d = embedded_function_control_q;
        TAWAD_ADDR_FUNC_STATUS: rdata_d = 8'(angle_flag_q) << TAWAD_ANGLE_FLAG_BIT
          | 8'(tilt_flag_q) << TAWAD_TILT_FLAG_BIT;
        TAWAD_ADDR_AXIS_SRC: rdata_d = axis_src_q;
        TAWAD_ADDR_ANGLE_THR: rdata_d = angle_thr_q;
        TAWAD_ADDR_ANGLE_LAT: rdata_d = angle_lat_q;
        TAWAD_ADDR_AXIS_MASK: rdata_d = axis_mask_q;
        TAWAD_ADDR_TILT_WIN: rdata_d = tilt_win_q;
        TAWAD_ADDR_TILT_THR: rdata_d = tilt_thr_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      angle_flag_q <= 1'b0;
      tilt_flag_q <= 1'b0;
      axis_src_q <= 8'h00;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      angle_flag_q <= angle_flag_d;
      tilt_flag_q <= tilt_flag_d;
      axis_src_q <= axis_src_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign second_irq_pin = irq_q;

  // ==========================================================
  // checks
  flag_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && angle_evt) |=> angle_flag_q)
    else $error("angle event did not set the status flag");
  read_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && rd_src2 && !angle_evt && latched && route_angle && !route_tilt)
      |=> (!angle_flag_q && !second_irq_pin))
    else $error("latched pin not cleared by status read");
  route_pin_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && angle_evt && route_angle) |=> second_irq_pin)
    else $error("routed angle event missing on pin");
  no_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && !route_angle && !route_tilt) |=> !second_irq_pin)
    else $error("pin asserted with routing off");
  enable_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!angle_en && $past(!angle_en)) |-> !angle_evt)
    else $error("angle event while function disabled");
  axis_src_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && angle_evt) |=> (axis_src_q[7:2] == {$past(semi_fire[0]), $past(semi_fire[1]),
      $past(semi_fire[2]), $past(semi_fire[3]), $past(semi_fire[4]), $past(semi_fire[5])}))
    else $error("axis source does not match triggering semi-axis");
  tilt_win_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tilt_state_q == TAWAD_T_CMP) |-> ($past(win_cnt_q) == win_len - 8'h01))
    else $error("tilt compare before window complete");
  tilt_evt_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tilt_evt_q |-> $past(tilt_state_q == TAWAD_T_CMP && ref_ok_q))
    else $error("tilt event outside a window compare");
  reset_axis_a: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> (axis_mask_q == TAWAD_RST_AXIS_MASK))
    else $error("reset axis selection is not positive x");
  angle_irq_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    angle_evt && route_angle ##1 second_irq_pin);
  tilt_irq_c: cover property (@(posedge sys_clk) disable iff (!reset_n) tilt_evt_q);
  read_clear_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    angle_flag_q && rd_src2 ##1 !angle_flag_q);
endmodule

/* File: tawad_pkg.sv */
package tawad_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] TAWAD_ADDR_PULSE_CFG = 8'h0b;
  localparam logic [7:0] TAWAD_ADDR_FUNC_CTRL = 8'h19;
  localparam logic [7:0] TAWAD_ADDR_FUNC_STATUS = 8'h54;
  localparam logic [7:0] TAWAD_ADDR_AXIS_SRC = 8'h55;
  localparam logic [7:0] TAWAD_ADDR_ANGLE_THR = 8'h59;
  localparam logic [7:0] TAWAD_ADDR_ANGLE_LAT = 8'h5a;
  localparam logic [7:0] TAWAD_ADDR_AXIS_MASK = 8'h5b;
  localparam logic [7:0] TAWAD_ADDR_TILT_WIN = 8'h5c;
  localparam logic [7:0] TAWAD_ADDR_TILT_THR = 8'h5d;
  // ==========================================================
  // field positions
  localparam int TAWAD_ROUTE_ANGLE_BIT = 0;
  localparam int TAWAD_ROUTE_TILT_BIT = 1;
  localparam int TAWAD_LATCH_BIT = 7;
  localparam int TAWAD_FUNCTION_ENABLE_BIT = 2;
  localparam int TAWAD_TILT_EN_BIT = 3;
  localparam int TAWAD_ANGLE_EN_BIT = 7;
  localparam int TAWAD_ANGLE_FLAG_BIT = 0;
  localparam int TAWAD_TILT_FLAG_BIT = 1;
  // ==========================================================
  // reset values
  localparam logic [7:0] TAWAD_RST_PULSE_CFG = 8'h00;
  localparam logic [7:0] TAWAD_RST_FUNC_CTRL = 8'h00;
  localparam logic [7:0] TAWAD_RST_AXIS_MASK = 8'h80;
  localparam logic [7:0] TAWAD_RST_ANGLE_THR = 8'h40;
  localparam logic [7:0] TAWAD_RST_ANGLE_LAT = 8'h05;
  localparam logic [7:0] TAWAD_RST_TILT_WIN = 8'h02;
  localparam logic [7:0] TAWAD_RST_TILT_THR = 8'h10;
  // ==========================================================
  // scaling and rates
  localparam int TAWAD_THR_SHIFT = 7;
  localparam int TAWAD_ANGLE_RATE_HZ = 26;
  localparam int TAWAD_SYS_CLK_HZ = 40000000;
  localparam int TAWAD_SEMI_AXES = 6;
  // ==========================================================
  // tilt averaging states
  typedef enum logic [2:0] {
    TAWAD_T_IDLE = 3'b001,
    TAWAD_T_ACC = 3'b010,
    TAWAD_T_CMP = 3'b100
  } tawad_tilt_state_t;
endpackage

/* File: tawad_semi_axis.sv */
`timescale 1ns/1ps
// ==========================================================
// one semi-axis: above-threshold run length and event
module tawad_semi_axis import tawad_pkg::*; #(
  parameter int W = 16
) (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // sync reset, low active
  input wire logic clk_en, // freezes state when low
  input wire logic sample_stb, // new sample at detector rate
  input wire logic active, // function and axis enabled
  input wire logic signed [W:0] value, // projection on this semi-axis
  input wire logic signed [W:0] limit, // scaled threshold
  input wire logic [7:0] latency, // samples needed above limit
  output logic fire_q // one-cycle event
);
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic fire_d;
  logic [7:0] need;

  // zero latency still needs one sample above the limit
  assign need = (latency == 8'h00) ? 8'h01 : latency;

  // run counter saturates so a long hold fires only once
  always_comb begin
    count_d = count_q;
    fire_d = 1'b0;
    if (sample_stb) begin
      if (active && (value > limit)) begin
        if (count_q != 8'hff) begin
          count_d = count_q + 8'h01;
        end
        fire_d = (count_d == need) && (count_q != need);
      end else begin
        count_d = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count_q <= 8'h00;
      fire_q <= 1'b0;
    end else if (clk_en) begin
      count_q <= count_d;
      fire_q <= fire_d;
    end
  end

  // ==========================================================
  // checks
  fire_cause_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && $rose(fire_q) && $past(clk_en)) |->
      $past(sample_stb && active && value > limit && count_d == need))
    else $error("semi-axis event without a full run above limit");
  run_restart_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && sample_stb && !(active && value > limit)) |=> (count_q == 8'h00))
    else $error("run counter not restarted at or below limit");
  run_step_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && !sample_stb) |=> $stable(count_q))
    else $error("run counter moved without a sample");
  fire_seen_c: cover property (@(posedge sys_clk) disable iff (!reset_n) fire_q);
endmodule

/* File: tawad_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host side: feeds accel samples and watches the second irq pin
module tawad_host_model #(
  parameter int W = 16,
  parameter int GAP = 8
) (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // sync reset, low active
  input wire logic second_irq_pin, // irq from the block
  output logic sample_stb, // one-cycle sample valid
  output logic signed [W-1:0] acc_x, // accel x sample
  output logic signed [W-1:0] acc_y, // accel y sample
  output logic signed [W-1:0] acc_z // accel z sample
);
  int irq_rises = 0;
  logic irq_prev = 1'b0;

  initial begin
    sample_stb = 1'b0;
    acc_x = '0;
    acc_y = '0;
    acc_z = '0;
  end

  // count irq rising edges, as an edge-triggered host handler would
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_rises <= 0;
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= second_irq_pin;
      if (second_irq_pin && !irq_prev) begin
        irq_rises <= irq_rises + 1;
      end
    end
  end

  // one sample every GAP+2 cycles stands in for a rate of 26 Hz or faster;
  // the real period is far too long to simulate, and the block only counts strobes
  task automatic send(input logic signed [W-1:0] x, y, z);
    @(posedge sys_clk);
    #1;
    sample_stb = 1'b1;
    acc_x = x;
    acc_y = y;
    acc_z = z;
    @(posedge sys_clk);
    #1;
    sample_stb = 1'b0;
    // stale values must not pass for a fresh sample
    acc_x = ~x;
    acc_y = ~y;
    acc_z = ~z;
    repeat (GAP) @(posedge sys_clk);
  endtask
endmodule

/* File: test_tilt_and_wrist_angle_detector.sv */
`timescale 1ns/1ps
// ==========================================================
// register-level tests of the tilt and angle detector
module test_tilt_and_wrist_angle_detector import tawad_pkg::*;;
  localparam logic signed [15:0] HI = 16'sh3000;
  localparam logic signed [15:0] LIM = 16'sh2000;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic sample_stb;
  logic signed [15:0] acc_x, acc_y, acc_z;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic second_irq_pin;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] rst_addr [10] = '{8'h0b, 8'h19, 8'h54, 8'h55, 8'h59, 8'h5a, 8'h5b, 8'h5c,
    8'h5d, 8'h33};
  logic [7:0] rst_val [10] = '{TAWAD_RST_PULSE_CFG, TAWAD_RST_FUNC_CTRL, 8'h00, 8'h00,
    TAWAD_RST_ANGLE_THR, TAWAD_RST_ANGLE_LAT, TAWAD_RST_AXIS_MASK, TAWAD_RST_TILT_WIN,
    TAWAD_RST_TILT_THR, 8'h00};

  // 25 ns period, 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  tawad_top #(.W(16)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .sample_stb(sample_stb),
    .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .second_irq_pin(second_irq_pin)
  );

  tawad_host_model #(.W(16), .GAP(8)) i_host (
    .sys_clk(sys_clk), .reset_n(reset_n), .second_irq_pin(second_irq_pin),
    .sample_stb(sample_stb), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z)
  );

  // ==========================================================
  // register port and compare tasks
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // data is taken two edges on; it holds until the next read anyway
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    chk(d, exp);
  endtask

  task automatic irq_chk(input int exp);
    chk(8'(i_host.irq_rises), 8'(exp));
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    $display("watchdog expired at %0t", $time);
    test_done;
  end

  // ==========================================================
  // main sequence
  initial begin
    int i;
    int base;
    logic [7:0] junk;
    repeat (12) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    // reset values, unmapped read, writes to status ignored
    for (i = 0; i < 10; i++) rd_chk(rst_addr[i], rst_val[i]);
    reg_write(TAWAD_ADDR_FUNC_STATUS, 8'hff);
    reg_write(TAWAD_ADDR_AXIS_SRC, 8'hff);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    rd_chk(TAWAD_ADDR_AXIS_SRC, 8'h00);
    $display("test reset_values done");
    // either enable alone must keep the angle function quiet
    reg_write(TAWAD_ADDR_ANGLE_LAT, 8'h01);
    reg_write(TAWAD_ADDR_PULSE_CFG, 8'h01);
    base = i_host.irq_rises;
    for (i = 0; i < 2; i++) begin
      reg_write(TAWAD_ADDR_FUNC_CTRL, (i == 0) ? 8'h04 : 8'h80);
      repeat (3) i_host.send(HI, 0, 0);
      i_host.send(0, 0, 0);
    end
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    irq_chk(base);
    $display("test enables done");
    // latency 3, a sample equal to the limit restarts the run
    reg_write(TAWAD_ADDR_ANGLE_LAT, 8'h03);
    reg_write(TAWAD_ADDR_FUNC_CTRL, 8'h84);
    rd_chk(TAWAD_ADDR_FUNC_CTRL, 8'h84);
    repeat (2) i_host.send(HI, 0, 0);
    i_host.send(LIM, 0, 0);
    repeat (2) i_host.send(HI, 0, 0);
    irq_chk(base);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    i_host.send(HI, 0, 0);
    irq_chk(base + 1);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h01);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    rd_chk(TAWAD_ADDR_AXIS_SRC, 8'h80);
    // a continuing run gives no second event
    repeat (4) i_host.send(HI, 0, 0);
    irq_chk(base + 1);
    // routing off: flag still set, pin quiet
    reg_write(TAWAD_ADDR_PULSE_CFG, 8'h00);
    i_host.send(0, 0, 0);
    repeat (3) i_host.send(HI, 0, 0);
    irq_chk(base + 1);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h01);
    $display("test latency done");
    // latched pin holds until the status read
    reg_write(TAWAD_ADDR_PULSE_CFG, 8'h81);
    i_host.send(0, 0, 0);
    repeat (3) i_host.send(HI, 0, 0);
    repeat (6) @(posedge sys_clk);
    #1;
    chk({7'h00, second_irq_pin}, 8'h01);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h01);
    chk({7'h00, second_irq_pin}, 8'h00);
    $display("test latched done");
    // only the chosen semi-axis counts
    reg_write(TAWAD_ADDR_AXIS_MASK, 8'h10);
    i_host.send(0, 0, 0);
    repeat (3) i_host.send(HI, 0, 0);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    repeat (3) i_host.send(0, -HI, 0);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h01);
    rd_chk(TAWAD_ADDR_AXIS_SRC, 8'h10);
    $display("test axis done");
    // tilt: window of 2, first window only sets the reference
    reg_write(TAWAD_ADDR_FUNC_CTRL, 8'h0c);
    reg_write(TAWAD_ADDR_TILT_WIN, 8'h01);
    reg_read(TAWAD_ADDR_FUNC_STATUS, junk);
    repeat (2) i_host.send(16'sh1000, 0, 0);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    repeat (2) i_host.send(16'sh1080, 0, 0);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    // tilt routed to the pin gives one unlatched pulse
    reg_write(TAWAD_ADDR_PULSE_CFG, 8'h02);
    base = i_host.irq_rises;
    repeat (2) i_host.send(0, 0, 0);
    irq_chk(base + 1);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h02);
    // a higher threshold hides the same size of change
    reg_write(TAWAD_ADDR_TILT_THR, 8'h40);
    repeat (2) i_host.send(16'sh1000, 0, 0);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h00);
    irq_chk(base + 1);
    $display("test tilt done");
    // frozen clock enable: samples and writes are not taken
    reg_write(TAWAD_ADDR_FUNC_CTRL, 8'h84);
    reg_write(TAWAD_ADDR_AXIS_MASK, 8'h80);
    reg_write(TAWAD_ADDR_PULSE_CFG, 8'h01);
    i_host.send(0, 0, 0);
    @(posedge sys_clk);
    #1;
    clk_en = 1'b0;
    repeat (3) i_host.send(HI, 0, 0);
    reg_write(TAWAD_ADDR_ANGLE_LAT, 8'h01);
    @(posedge sys_clk);
    #1;
    clk_en = 1'b1;
    base = i_host.irq_rises;
    repeat (2) i_host.send(HI, 0, 0);
    irq_chk(base);
    rd_chk(TAWAD_ADDR_ANGLE_LAT, 8'h03);
    i_host.send(HI, 0, 0);
    irq_chk(base + 1);
    rd_chk(TAWAD_ADDR_FUNC_STATUS, 8'h01);
    $display("test freeze done");
    test_done;
  end
endmodule
